//--- pkg/pmcs_pkg.sv
// constants and types for the power mode and clock select block
package pmcs_pkg;
    // special function register addresses
    localparam logic [7:0] power_mode_control_addr   = 8'hbe;
    localparam logic [7:0] clock_source_control_addr = 8'hc6;
    localparam logic [7:0] cpu_power_control_addr    = 8'h87;
    // power mode control field positions
    localparam int fast_crystal_ready_bit  = 6;
    localparam int fast_rc_ready_bit       = 5;
    localparam int reset_cause_lsb         = 3;
    localparam int unused_osc_powerdown_bit = 2;
    localparam int mode_lsb                = 0;
    // clock source control and cpu power control field positions
    localparam int slow_clock_select_bit   = 7;
    localparam int main_clock_select_bit   = 6;
    localparam int timer_tick_rate_lsb     = 3;
    localparam int idle_bit                = 0;
    // reset values and codes
    localparam logic [1:0] mode_reset        = 2'h0;
    localparam logic [2:0] tick_rate_reset   = 3'h1;
    localparam logic [2:0] clk_reserved_reset = 3'h1;
    localparam logic [1:0] cause_power_on    = 2'h0;
    localparam logic [1:0] cause_external    = 2'h1;
    localparam logic [1:0] cause_watchdog    = 2'h2;
    localparam logic       sel_crystal       = 1'b0;
    localparam logic       sel_rc            = 1'b1;
    // tick divider width: code 111 divides 32 MHz by 128
    localparam int tick_div_width = 7;
    // power modes, one-hot
    typedef enum logic [3:0] {
        active_state      = 4'h1,
        light_sleep_state = 4'h2,
        standby_state     = 4'h4,
        deep_sleep_state  = 4'h8
    } power_state_t;
endpackage

//--- logic/ready_sync.sv
// two-flop synchroniser for the oscillator ready levels
`timescale 1ns/100ps
module ready_sync #(
    parameter int width = 2
) (
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic [width-1:0] async_in,
    output logic      [width-1:0] sync_out
);
    logic [width-1:0] meta_q;
    logic [width-1:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

//--- logic/power_mode_clock_select.sv
// power mode selection, oscillator control, clock switching and tick prescaler
`timescale 1ns/100ps
module power_mode_clock_select (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic [1:0] reset_cause,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic       fast_crystal_stable,
    input  wire logic       fast_rc_stable,
    input  wire logic       calibration_busy,
    input  wire logic       wake_event,
    output logic      [7:0] sfr_rdata,
    output logic            fast_crystal_osc_on,
    output logic            fast_rc_osc_on,
    output logic            main_clock_is_rc,
    output logic            slow_clock_is_rc,
    output logic            timer_tick,
    output logic      [3:0] power_state
);
    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [1:0] mode_q, mode_d;
    logic       pd_q, pd_d;
    logic       pd_pending_q, pd_pending_d;
    logic [1:0] cause_q, cause_d;
    logic       cause_taken_q, cause_taken_d;
    logic       slow_sel_q, slow_sel_d;
    logic       main_sel_q, main_sel_d;
    logic [2:0] tick_rate_q, tick_rate_d;
    logic [2:0] reserved_q, reserved_d;
    logic       active_src_q, active_src_d;
    logic [7:0] rdata_q, rdata_d;
    logic       xtal_on_q, xtal_on_d;
    logic       rc_on_q, rc_on_d;
    logic       tick_q, tick_d;
    logic [pmcs_pkg::tick_div_width-1:0] div_q, div_d;
    pmcs_pkg::power_state_t state_q, state_d;
    logic [1:0] ready_lvl;
    logic       xtal_rdy;
    logic       rc_rdy;
    logic       wr_pm;
    logic       wr_clk;
    logic       wr_idle;

    // ready levels into the clock domain
    ready_sync #(.width(2)) ready_sync_inst (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in ({fast_crystal_stable, fast_rc_stable}),
        .sync_out (ready_lvl)
    );
    assign xtal_rdy = ready_lvl[1];
    assign rc_rdy   = ready_lvl[0];

    assign wr_pm   = sfr_wr && (sfr_addr == pmcs_pkg::power_mode_control_addr);
    assign wr_clk  = sfr_wr && (sfr_addr == pmcs_pkg::clock_source_control_addr);
    assign wr_idle = sfr_wr && (sfr_addr == pmcs_pkg::cpu_power_control_addr)
                     && sfr_wdata[pmcs_pkg::idle_bit];

    // decode a one-hot power state from the mode field
    function automatic pmcs_pkg::power_state_t mode_to_state(input logic [1:0] m);
        case (m)
            2'h0:    mode_to_state = pmcs_pkg::active_state;
            2'h1:    mode_to_state = pmcs_pkg::light_sleep_state;
            2'h2:    mode_to_state = pmcs_pkg::standby_state;
            default: mode_to_state = pmcs_pkg::deep_sleep_state;
        endcase
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        mode_d        = mode_q;
        pd_d          = pd_q;
        pd_pending_d  = pd_pending_q;
        cause_d       = cause_q;
        cause_taken_d = 1'b1;
        slow_sel_d    = slow_sel_q;
        main_sel_d    = main_sel_q;
        tick_rate_d   = tick_rate_q;
        reserved_d    = reserved_q;
        active_src_d  = active_src_q;
        state_d       = state_q;
        // capture the cause once after reset release
        if (!cause_taken_q)
        begin
            cause_d = reset_cause;
        end
        // power mode control writes; read-only and unused bits ignored
        if (wr_pm)
        begin
            mode_d = sfr_wdata[pmcs_pkg::mode_lsb +: 2];
            if (sfr_wdata[pmcs_pkg::unused_osc_powerdown_bit] && calibration_busy)
            begin
                pd_pending_d = 1'b1;
            end
            else
            begin
                pd_d         = sfr_wdata[pmcs_pkg::unused_osc_powerdown_bit];
                pd_pending_d = 1'b0;
            end
        end
        else if (pd_pending_q && !calibration_busy)
        begin
            pd_d         = 1'b1;
            pd_pending_d = 1'b0;
        end
        // clock control writes
        if (wr_clk)
        begin
            slow_sel_d  = sfr_wdata[pmcs_pkg::slow_clock_select_bit];
            main_sel_d  = sfr_wdata[pmcs_pkg::main_clock_select_bit];
            tick_rate_d = sfr_wdata[pmcs_pkg::timer_tick_rate_lsb +: 3];
            reserved_d  = sfr_wdata[2:0];
        end
        // a change of main select drops the power-down setting
        if (main_sel_d != main_sel_q)
        begin
            pd_d         = 1'b0;
            pd_pending_d = 1'b0;
        end
        // in active state switch the system clock only onto a stable oscillator; a wake selects rc at once
        if (state_q == pmcs_pkg::active_state)
        begin
            if (main_sel_q == pmcs_pkg::sel_crystal && xtal_rdy)
                active_src_d = pmcs_pkg::sel_crystal;
            else if (main_sel_q == pmcs_pkg::sel_rc && rc_rdy)
                active_src_d = pmcs_pkg::sel_rc;
        end
        // power state machine
        case (state_q)
            pmcs_pkg::active_state:
            begin
                if (wr_idle)
                    state_d = mode_to_state(mode_q);
            end
            pmcs_pkg::light_sleep_state,
            pmcs_pkg::standby_state,
            pmcs_pkg::deep_sleep_state:
            begin
                if (wake_event)
                begin
                    state_d      = pmcs_pkg::active_state;
                    mode_d       = pmcs_pkg::mode_reset;
                    active_src_d = pmcs_pkg::sel_rc;
                end
            end
            default: state_d = pmcs_pkg::active_state;
        endcase
    end

    // oscillator power, read data and tick prescaler
    always_comb
    begin
        // in active state both on unless power-down set; selected one, and rc while in use, requested on; both off when asleep
        xtal_on_d  = (state_q == pmcs_pkg::active_state)
                     && (!pd_d || main_sel_d == pmcs_pkg::sel_crystal);
        rc_on_d    = (state_q == pmcs_pkg::active_state)
                     && (!pd_d || main_sel_d == pmcs_pkg::sel_rc
                         || active_src_d == pmcs_pkg::sel_rc);
        rdata_d = 8'h00;
        if (sfr_rd)
        begin
            case (sfr_addr)
                pmcs_pkg::power_mode_control_addr:
                    rdata_d = {1'b0, xtal_rdy, rc_rdy, cause_q, pd_q, mode_q};
                pmcs_pkg::clock_source_control_addr:
                    rdata_d = {slow_sel_q, main_sel_q, tick_rate_q, reserved_q};
                default:
                    rdata_d = 8'h00; // idle bit reads 0
            endcase
        end
        // tick divider: period 2^code cycles of the 32 MHz reference
        div_d  = div_q + 1'b1;
        tick_d = 1'b0;
        if ((div_q & ((7'h1 << tick_rate_q) - 7'h1)) == 7'h0)
            tick_d = (state_q == pmcs_pkg::active_state);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_q        <= pmcs_pkg::mode_reset;
            pd_q          <= 1'b0;
            pd_pending_q  <= 1'b0;
            cause_q       <= pmcs_pkg::cause_power_on;
            cause_taken_q <= 1'b0;
            slow_sel_q    <= pmcs_pkg::sel_rc;
            main_sel_q    <= pmcs_pkg::sel_rc;
            tick_rate_q   <= pmcs_pkg::tick_rate_reset;
            reserved_q    <= pmcs_pkg::clk_reserved_reset;
            active_src_q  <= pmcs_pkg::sel_rc;
            state_q       <= pmcs_pkg::active_state;
            rdata_q       <= 8'h00;
            xtal_on_q     <= 1'b1;
            rc_on_q       <= 1'b1;
            tick_q        <= 1'b0;
            div_q         <= '0;
        end
        else
        begin
            mode_q        <= mode_d;
            pd_q          <= pd_d;
            pd_pending_q  <= pd_pending_d;
            cause_q       <= cause_d;
            cause_taken_q <= cause_taken_d;
            slow_sel_q    <= slow_sel_d;
            main_sel_q    <= main_sel_d;
            tick_rate_q   <= tick_rate_d;
            reserved_q    <= reserved_d;
            active_src_q  <= active_src_d;
            state_q       <= state_d;
            rdata_q       <= rdata_d;
            xtal_on_q     <= xtal_on_d;
            rc_on_q       <= rc_on_d;
            tick_q        <= tick_d;
            div_q         <= div_d;
        end
    end

    assign sfr_rdata           = rdata_q;
    assign fast_crystal_osc_on = xtal_on_q;
    assign fast_rc_osc_on      = rc_on_q;
    assign main_clock_is_rc    = active_src_q;
    assign slow_clock_is_rc    = slow_sel_q;
    assign timer_tick          = tick_q;
    assign power_state         = state_q;
endmodule

//--- tb/pmcs_properties.sv
// assertion checker for the power mode and clock select block
`timescale 1ns/100ps
module pmcs_checker (
    input wire logic       ref_clk,
    input wire logic       resetn,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_rd,
    input wire logic       fast_crystal_stable,
    input wire logic       fast_rc_stable,
    input wire logic       wake_event,
    input wire logic [7:0] sfr_rdata,
    input wire logic       fast_crystal_osc_on,
    input wire logic       fast_rc_osc_on,
    input wire logic       main_clock_is_rc,
    input wire logic [3:0] power_state
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // read data stays low outside a read answer
    AST_RDATA_QUIET: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_UNUSED_BIT: assert property (sfr_rd && sfr_addr == 8'hbe |=> !sfr_rdata[7])
        else $error("unused status bit reads one");
    // ready bits follow a settled oscillator level
    AST_XTAL_READY: assert property ($stable(fast_crystal_stable)[*4] ##0 sfr_rd && sfr_addr == 8'hbe
        |=> sfr_rdata[6] == $past(fast_crystal_stable)) else $error("crystal ready bit wrong");
    AST_RC_READY: assert property ($stable(fast_rc_stable)[*4] ##0 sfr_rd && sfr_addr == 8'hbe
        |=> sfr_rdata[5] == $past(fast_rc_stable)) else $error("rc ready bit wrong");
    // switch to crystal only after its synchronised ready level
    AST_SWITCH_WAIT: assert property ($fell(main_clock_is_rc) |-> $past(fast_crystal_stable, 3))
        else $error("main clock switched before crystal ready");
    // in active state, from its second cycle, the source in use is never the powered-down one
    AST_OSC_PAIR: assert property ((power_state == pmcs_pkg::active_state)[*2] |->
        (fast_crystal_osc_on || main_clock_is_rc) && (fast_rc_osc_on || !main_clock_is_rc))
        else $error("main source powered down");
    AST_WAKE: assert property (power_state != pmcs_pkg::active_state && wake_event
        |=> power_state == pmcs_pkg::active_state) else $error("wake did not reach active state");
    AST_LEAVE_LIGHT: assert property ($past(power_state) == pmcs_pkg::light_sleep_state
        && power_state == pmcs_pkg::active_state |-> main_clock_is_rc) else $error("not on rc after light sleep");
endmodule

bind power_mode_clock_select pmcs_checker pmcs_checker_inst (.*);

//--- tb/power_mode_clock_select_tb_top.sv
// self-checking bench for the power mode and clock select block
`timescale 1ns/100ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
    $display("wrong value %s exp %h got %h", n, e, a); end end
module power_mode_clock_select_tb_top;
    logic       ref_clk = 1'b0;
    logic       resetn = 1'b0;
    logic [1:0] reset_cause = 2'h0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic       sfr_wr = 1'b0;
    logic       sfr_rd = 1'b0;
    logic       fast_crystal_stable = 1'b0;
    logic       fast_rc_stable = 1'b0;
    logic       calibration_busy = 1'b0;
    logic       wake_event = 1'b0;
    logic       xtal_allow = 1'b0;
    logic [7:0] sfr_rdata;
    logic       fast_crystal_osc_on;
    logic       fast_rc_osc_on;
    logic       main_clock_is_rc;
    logic       slow_clock_is_rc;
    logic       timer_tick;
    logic [3:0] power_state;
    int         num_errors = 0;
    int         samples_checked = 0;
    int         cnt;

    power_mode_clock_select power_mode_clock_select_inst (.*);

    // clock source
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end

    // oscillators report ready while powered, the crystal only while xtal_allow is set
    always @(negedge ref_clk)
    begin
        fast_crystal_stable <= fast_crystal_osc_on & xtal_allow;
        fast_rc_stable <= fast_rc_osc_on;
    end

    // ---------------------------------------------------------------
    // access tasks
    // ---------------------------------------------------------------
    task automatic summarize();
        if (num_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic rst(input logic [1:0] c);
        resetn = 1'b0;
        reset_cause = c;
        cyc(20);
        resetn = 1'b1;
        cyc(4);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        cyc(1);
        sfr_wr = 1'b0;
        cyc(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        sfr_addr = a;
        sfr_rd = 1'b1;
        cyc(1);
        sfr_rd = 1'b0;
        `CHK(n, e, sfr_rdata)
        cyc(1);
    endtask

    task automatic wait_crystal();
        for (cnt = 0; cnt < 20 && main_clock_is_rc !== 1'b0; cnt++)
            cyc(1);
        if (main_clock_is_rc !== 1'b0)
        begin
            num_errors++;
            summarize();
        end
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    initial
    begin
        rst(2'h0);
        rd(8'hbe, 8'h20, "status after reset");
        rd(8'hc6, 8'hc9, "clock reg after reset");
        rd(8'h87, 8'h00, "idle reg");
        rd(8'h55, 8'h00, "unmapped");
        for (int m = 0; m < 4; m++)
        begin
            wr(8'hbe, 8'hf8 | 8'(m));
            rd(8'hbe, 8'h20 | 8'(m), "mode field");
        end
        wr(8'hbe, 8'h04);
        rd(8'hbe, 8'h24, "powerdown set");
        `CHK("crystal off", 1'b0, fast_crystal_osc_on)
        wr(8'hc6, 8'h88);
        `CHK("crystal powered up", 1'b1, fast_crystal_osc_on)
        rd(8'hbe, 8'h20, "powerdown cleared");
        cyc(5);
        `CHK("still on rc", 1'b1, main_clock_is_rc)
        xtal_allow = 1'b1;
        wait_crystal();
        rd(8'hbe, 8'h60, "crystal ready");
        rd(8'hc6, 8'h88, "clock reg");
        calibration_busy = 1'b1;
        wr(8'hbe, 8'h04);
        rd(8'hbe, 8'h60, "powerdown deferred");
        calibration_busy = 1'b0;
        cyc(6);
        rd(8'hbe, 8'h44, "powerdown after calibration");
        `CHK("rc off", 1'b0, fast_rc_osc_on)
        for (int n = 0; n < 8; n++)
        begin
            wr(8'hc6, 8'h80 | 8'(n << 3));
            cyc(8);
            cnt = 0;
            repeat (256)
            begin
                cyc(1);
                cnt += int'(timer_tick === 1'b1);
            end
            `CHK("tick count", 256 >> n, cnt)
        end
        wr(8'hc6, 8'h08);
        `CHK("slow crystal", 1'b0, slow_clock_is_rc)
        for (int m = 1; m < 4; m++)
        begin
            wr(8'hbe, 8'(m));
            wr(8'h87, 8'h01);
            `CHK("sleep state", 4'(1 << m), power_state)
            cyc(4);
            wake_event = 1'b1;
            cyc(1);
            wake_event = 1'b0;
            `CHK("woken", pmcs_pkg::active_state, power_state)
            `CHK("rc after wake", 1'b1, main_clock_is_rc)
            wait_crystal();
            rd(8'hbe, 8'h60, "mode cleared");
        end
        xtal_allow = 1'b0;
        for (int c = 1; c < 3; c++)
        begin
            rst(2'(c));
            rd(8'hbe, 8'h20 | 8'(c << 3), "reset cause");
        end
        summarize();
    end
endmodule
